// ### logic/dma_chan_cfg.sv
// channel configuration, enable sequencing and ahb-lite register slave
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`include "dma_chan_cfg_params.svh"
`timescale 1ns/10ps
`default_nettype none
module dma_chan_cfg
    import dma_chan_pkg::*;
#(
    parameter int CNT_W = `CTRL_CNT_W
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [11:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // peripheral request lines
    input  wire logic [15:0] dma_req_i,
    // channel status
    output logic             busy_o,
    output logic             xfer_ack_o,
    output logic [3:0]       req_line_o,
    output logic             irq_o
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0]      cfg_r;
    logic [CNT_W-1:0] count_r;
    logic             tc_ie_r;
    logic [1:0]       irq_stat_r;
    logic [1:0]       irq_mask_r;
    ch_state_t        state_r;
    logic             ap_wr_r;
    logic             ap_rd_r;
    logic [11:0]      ap_addr_r;
    logic             push;
    logic             pop;
    logic             flush;
    logic             fifo_full;
    logic             fifo_act;

    wire logic [2:0] flow     = cfg_r[`CFG_FLOW_LSB+2:`CFG_FLOW_LSB]; // R1
    wire logic [3:0] dst_line = cfg_r[`CFG_DST_LSB+3:`CFG_DST_LSB];   // R2
    wire logic [3:0] src_line = cfg_r[`CFG_SRC_LSB+3:`CFG_SRC_LSB];   // R3
    wire logic       enable   = cfg_r[`CFG_EN_BIT];
    wire logic       halt     = cfg_r[`CFG_HALT_BIT];

    function automatic logic [3:0] pick_line(input logic [2:0] f, input logic [3:0] s,
                                             input logic [3:0] d);
        // memory-to-peripheral watches the destination line, every other flow code the source line
        pick_line = (f == `FLOW_M2P) ? d : s; // R2 R3
    endfunction

    // ------------------------------------------------------------
    // ahb-lite address phase capture
    // ------------------------------------------------------------
    // write data arrives one cycle after its address, so the address is held for the data phase
    wire logic ap_valid = hsel_i && htrans_i[1] && hready_i;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ap_wr_r   <= 1'b0;
            ap_rd_r   <= 1'b0;
            ap_addr_r <= 12'h000;
        end else begin
            ap_wr_r   <= ap_valid && hwrite_i;
            ap_rd_r   <= ap_valid && !hwrite_i;
            ap_addr_r <= haddr_i;
        end
    end

    wire logic wr_cfg  = ap_wr_r && ap_addr_r == `OFS_CFG;
    wire logic wr_ctrl = ap_wr_r && ap_addr_r == `OFS_CTRL;
    wire logic en_fall = wr_cfg && enable && !hwdata_i[`CFG_EN_BIT];

    // ------------------------------------------------------------
    // transfer sequencing
    // ------------------------------------------------------------
    // memory copies move one beat a cycle until the fifo fills, then one every other cycle; peripheral flows need a request per beat
    // the watched line is chosen by flow, so a memory end never gates a beat
    // a count of zero leaves the channel busy with no beats: load a count first
    wire logic m2m      = (flow == `FLOW_M2M);
    wire logic hw_req   = dma_req_i[pick_line(flow, src_line, dst_line)];
    wire logic cnt_zero = (count_r == '0);
    // a beat waits while the fifo is full, so every counted beat is pushed and acknowledged
    wire logic beat     = (state_r == CH_MOVE) && !cnt_zero && !fifo_full;
    wire logic last     = beat && count_r == CNT_W'(1);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_r <= CH_IDLE;
        end else if (!enable || en_fall) begin
            state_r <= CH_IDLE;
        end else begin
            case (state_r)
                CH_IDLE: begin
                    if (m2m) begin
                        state_r <= CH_MOVE; // R5 R11
                    end else begin
                        state_r <= CH_WAIT_REQ;
                    end
                end
                CH_WAIT_REQ: begin
                    if (!m2m && !halt && hw_req) begin
                        state_r <= CH_MOVE; // R10 R12
                    end
                end
                CH_MOVE: begin
                    if (last) begin
                        state_r <= CH_IDLE;
                    end else if (!m2m) begin
                        state_r <= CH_WAIT_REQ;
                    end
                end
                default: state_r <= CH_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            count_r <= '0;
            tc_ie_r <= 1'b0;
        end else if (wr_ctrl) begin
            count_r <= hwdata_i[CNT_W-1:0];
            tc_ie_r <= hwdata_i[`CTRL_TC_BIT];
        end else if (beat) begin
            count_r <= count_r - CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // fifo occupancy
    // ------------------------------------------------------------
    // occupancy only: no data is stored, the level stands for words in flight
    // the level drains one word a cycle whenever nothing is pushed
    // a disable in mid-transfer flushes the level, so buffered words are lost
    // and software has to reinitialise the channels before the next start
    assign push  = beat;
    assign pop   = fifo_act && !push;
    assign flush = en_fall && (state_r != CH_IDLE); // R7

    dma_chan_fifo_track #(
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .push_i      (push),
        .pop_i       (pop),
        .flush_i     (flush),
        .full_o      (fifo_full),
        .not_empty_o (fifo_act)
    );

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    localparam logic [31:0] CFG_WMASK = 32'h0005_FBDF; // R15

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cfg_r <= `CFG_RST;
        end else if (wr_cfg) begin
            cfg_r <= hwdata_i & CFG_WMASK; // R4
        end else if (last) begin
            cfg_r[`CFG_EN_BIT] <= 1'b0; // R6
        end
    end

    // ------------------------------------------------------------
    // interrupts: set wins over write-one-to-clear
    // ------------------------------------------------------------
    // status bit 0: transfer end, bit 1: fifo flushed by a mid-transfer disable
    // the output looks at the next status value, so it follows status without extra lag
    wire logic [1:0] irq_set = {flush, last && cfg_r[`CFG_ITC_BIT] && tc_ie_r}; // R14
    wire logic [1:0] irq_clr = (ap_wr_r && ap_addr_r == `OFS_IRQ_STAT) ? hwdata_i[1:0] : 2'h0;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_stat_r <= 2'h0;
            irq_mask_r <= 2'h0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            if (ap_wr_r && ap_addr_r == `OFS_IRQ_MASK) begin
                irq_mask_r <= hwdata_i[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read data and registered outputs
    // ------------------------------------------------------------
    // read data is registered at the address edge, so it stands through the data phase
    // and the slave never needs a wait state
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr_i)
            `OFS_CFG: begin
                rd_mux = cfg_r;
                rd_mux[`CFG_ACT_BIT] = fifo_act; // R13
            end
            `OFS_CTRL:     rd_mux = {tc_ie_r, {(31-CNT_W){1'b0}}, count_r};
            `OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat_r};
            `OFS_IRQ_MASK: rd_mux = {30'h0, irq_mask_r};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            hrdata_o   <= 32'h0000_0000;
            busy_o     <= 1'b0;
            xfer_ack_o <= 1'b0;
            req_line_o <= 4'h0;
            irq_o      <= 1'b0;
        end else begin
            if (ap_valid && !hwrite_i) begin
                hrdata_o <= rd_mux;
            end
            busy_o     <= (state_r != CH_IDLE);
            xfer_ack_o <= push;
            req_line_o <= pick_line(flow, src_line, dst_line);
            irq_o      <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
endmodule
`default_nettype wire

// ### logic/dma_chan_cfg_params.svh
// constants of the dma channel configuration block
// What this block does
// (R1) Bits 13 to 11 of the configuration register select the transfer mode, one code being memory-to-memory.
// (R2) Bits 9 to 6 hold the destination request line number, unused when the destination is memory.
// (R3) Bits 4 to 1 hold the source request line number, unused when the source is memory.
// (R4) Bit 0 enables the channel when one and disables it when zero.
// (R5) In memory-to-memory mode setting the enable bit starts the transfer.
// (R6) The enable bit clears itself when the transfer count reaches zero.
// (R7) Clearing the enable bit mid-transfer throws away the data held in the channel fifo.
// (R8) After a mid-transfer disable software must reset the channels before starting again.
// (R9) To pause cleanly software sets halt, polls active until zero, then clears enable.
// (R10) In memory-to-memory mode hardware request lines never start a transfer.
// (R11) Software starts a memory-to-memory transfer by writing one to the enable bit.
// (R12) Bit 18 set to zero accepts requests and set to one ignores them.
// (R13) Read-only bit 17 reads one while the channel fifo holds data and zero when empty.
// (R14) The transfer-end interrupt fires only when bit 15 and the control terminal count bit are set.
// (R15) Reserved bits 10 and 5 ignore what is written and read as zero.
`ifndef DMA_CHAN_CFG_PARAMS_SVH
`define DMA_CHAN_CFG_PARAMS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_CFG        12'h000
`define OFS_CTRL       12'h004
`define OFS_IRQ_STAT   12'h008
`define OFS_IRQ_MASK   12'h00C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CFG_EN_BIT     0
`define CFG_SRC_LSB    1
`define CFG_DST_LSB    6
`define CFG_FLOW_LSB   11
`define CFG_IE_BIT     14
`define CFG_ITC_BIT    15
`define CFG_LOCK_BIT   16
`define CFG_ACT_BIT    17
`define CFG_HALT_BIT   18
`define CTRL_TC_BIT    31
`define CTRL_CNT_W     12
`define FLOW_M2M       3'h0
`define FLOW_M2P       3'h1
`define FLOW_P2M       3'h2
`define FLOW_P2P       3'h3
`define IRQ_TC_BIT     0
`define IRQ_ERR_BIT    1
`define CFG_RST        32'h0000_0000
`define CTRL_RST       32'h0000_0000
`define FIFO_DEPTH     4

`endif

// ### logic/dma_chan_fifo_track.sv
// occupancy tracker of the channel fifo
`timescale 1ns/10ps
`default_nettype none
module dma_chan_fifo_track #(
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic  sys_clk_i,
    input  wire logic  srst_i,
    // control
    input  wire logic  push_i,
    input  wire logic  pop_i,
    input  wire logic  flush_i,
    // status
    output logic       full_o,
    output logic       not_empty_o
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [CW-1:0] level_r;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || flush_i) begin
            level_r <= '0;
        end else if (push_i && !pop_i && level_r != CW'(DEPTH)) begin
            level_r <= level_r + CW'(1);
        end else if (pop_i && !push_i && level_r != '0) begin
            level_r <= level_r - CW'(1);
        end
    end

    assign full_o      = (level_r == CW'(DEPTH));
    assign not_empty_o = (level_r != '0);
endmodule
`default_nettype wire

// ### logic/dma_chan_pkg.sv
// types of the dma channel configuration block
package dma_chan_pkg;
    typedef enum logic [1:0] {
        CH_IDLE,
        CH_WAIT_REQ,
        CH_MOVE
    } ch_state_t;
endpackage

// ### tb/dma_chan_cfg_bench.sv
// self-checking bench of the dma channel configuration block
`timescale 1ns/10ps
`default_nettype none
module dma_chan_cfg_bench;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] w;
        logic [31:0] e;
        logic [3:0]  l;
    } row_t;
    // unmapped place, every flow code with field extremes, then the mask
    row_t        rows [7] = '{'{12'h010, 32'hFFFF_FFFF, 32'h0, 4'h0},
        '{12'h000, 32'hFFFF_FFFE, 32'h0005_FBDE, 4'hF}, '{12'h000, 32'h0A8A, 32'h0A8A, 4'hA},
        '{12'h000, 32'h1428, 32'h1008, 4'h4}, '{12'h000, 32'h18A6, 32'h1886, 4'h3},
        '{12'h000, 32'h0, 32'h0, 4'h0}, '{12'h00C, 32'h3, 32'h3, 4'h0}};
    logic [31:0] m_ctl [3] = '{32'h8000_0005, 32'h8000_0003, 32'h0000_0002};
    logic [31:0] m_cfg [3] = '{32'h8001, 32'h0001, 32'h8001};
    logic        m_irq [3] = '{1'b1, 1'b0, 1'b0};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sel = 1'b0;
    logic        wr = 1'b0;
    logic        req_en = 1'b0;
    logic [1:0]  trans = 2'h0;
    logic [3:0]  req_ln = 4'h0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [31:0] q;
    int          errors = 0;
    int          n_tests = 0;
    int          acks = 0;
    int          base;
    wire         rdy, busy, ack, irq;
    wire [3:0]   line;
    wire [15:0]  req;
    wire [31:0]  rdata;
    dma_chan_cfg dma_chan_cfg_i (.sys_clk_i(clk), .srst_i(rst), .hsel_i(sel), .haddr_i(addr),
        .htrans_i(trans), .hwrite_i(wr), .hsize_i(3'h2), .hwdata_i(wdata), .hready_i(rdy),
        .hrdata_o(rdata), .hreadyout_o(rdy), .hresp_o(), .dma_req_i(req), .busy_o(busy),
        .xfer_ack_o(ack), .req_line_o(line), .irq_o(irq));
    dma_req_model dma_req_model_i (.sys_clk_i(clk), .srst_i(rst), .en_i(req_en),
        .line_i(req_ln), .xfer_ack_i(ack), .dma_req_o(req));
    always #5 clk = ~clk;
    always @(posedge clk) if (ack === 1'b1) acks <= acks + 1;
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        sel <= 1'b1;
        trans <= 2'h2;
        wr <= w;
        addr <= a;
        do @(posedge clk); while (rdy !== 1'b1);
        trans <= 2'h0;
        wdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        q = rdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        for (int t = 0; t < 300 && busy !== 1'b0; t++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].w);
            bus(1'b0, rows[i].a, 32'h0);
            chk("readback", rows[i].e, q);
            chk("watched line", {28'h0, rows[i].l}, {28'h0, line});
            $display("row %0d done", i);
        end
        // no request line is raised here: memory copies must run on the start bit alone
        foreach (m_ctl[k]) begin
            base = acks;
            bus(1'b1, 12'h004, m_ctl[k]);
            bus(1'b1, 12'h000, m_cfg[k]);
            settle;
            chk("beats", {20'h0, m_ctl[k][11:0]}, 32'(acks - base));
            bus(1'b0, 12'h000, 32'h0);
            chk("enable cleared", 32'h0, {31'h0, q[0]});
            chk("irq", {31'h0, m_irq[k]}, {31'h0, irq});
            bus(1'b1, 12'h008, 32'h3);
            repeat (3) @(posedge clk);
            chk("irq cleared", 32'h0, {31'h0, irq});
            $display("copy case %0d done", k);
        end
        req_ln <= 4'h3;
        req_en <= 1'b1;
        base = acks;
        bus(1'b1, 12'h004, 32'h4);
        bus(1'b1, 12'h000, 32'h0004_1007);
        repeat (20) @(posedge clk);
        chk("halted beats", 32'h0, 32'(acks - base));
        chk("halted busy", 32'h1, {31'h0, busy});
        bus(1'b0, 12'h000, 32'h0);
        chk("fifo active", 32'h0, {31'h0, q[17]});
        bus(1'b1, 12'h000, 32'h1007);
        settle;
        chk("released beats", 32'h4, 32'(acks - base));
        $display("halt test done");
        base = acks;
        // a memory copy keeps the fifo filled, so a disable has words to throw away
        bus(1'b1, 12'h004, 32'hFF);
        bus(1'b1, 12'h000, 32'h0001);
        for (int t = 0; t < 200 && acks - base < 2; t++) @(posedge clk);
        bus(1'b0, 12'h000, 32'h0);
        chk("fifo holds data", 32'h1, {31'h0, q[17]});
        bus(1'b1, 12'h000, 32'h0000);
        bus(1'b0, 12'h000, 32'h0);
        chk("fifo emptied", 32'h0, {31'h0, q[17]});
        repeat (3) @(posedge clk);
        bus(1'b0, 12'h008, 32'h0);
        chk("flush flag", 32'h2, q & 32'h2);
        chk("flush irq", 32'h1, {31'h0, irq});
        req_en <= 1'b0;
        $display("abort test done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a += 4) begin
            bus(1'b0, 12'(a), 32'h0);
            chk("reset value", 32'h0, q);
        end
        chk("irq after reset", 32'h0, {31'h0, irq});
        $display("reset test done");
        close_out;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out;
    end
endmodule
`default_nettype wire

// ### tb/dma_chan_cfg_chk.sv
// assertion checker of the dma channel configuration block
`timescale 1ns/10ps
`default_nettype none
module dma_chan_cfg_chk (
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        srst_i,
    // bus and status
    input wire logic        hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        busy_o,
    input wire logic        xfer_ack_o,
    input wire logic [3:0]  req_line_o,
    input wire logic        irq_o
);
    logic        wph_r;
    logic        cph_r;
    logic [31:0] cfg_r;
    wire logic   acc = hsel_i && htrans_i[1] && hready_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // shadow of the written word; only fields that never change by themselves are used
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wph_r <= 1'b0;
            cph_r <= 1'b0;
            cfg_r <= 32'h0;
        end else begin
            wph_r <= acc && hwrite_i;
            cph_r <= acc && hwrite_i && haddr_i == 12'h000;
            if (cph_r) begin
                cfg_r <= hwdata_i;
            end
        end
    end
    sequence s_halted;
        (cfg_r[18] && cfg_r[13:11] != 3'h0) [*3];
    endsequence
    a_ready_high: assert property (hreadyout_o) else $error("wait state seen");
    a_resp_okay: assert property (!hresp_o) else $error("error response seen");
    a_reset_quiet: assert property (disable iff (1'b0) srst_i |=> !busy_o && !irq_o && !xfer_ack_o)
        else $error("output active after reset");
    a_ack_busy: assert property (xfer_ack_o |-> busy_o || $past(busy_o))
        else $error("beat while idle");
    a_rdata_hold: assert property (!(acc && !hwrite_i) |=> $stable(hrdata_o))
        else $error("read data moved without a read");
    a_line_select: assert property ($stable(cfg_r) |->
        req_line_o == (cfg_r[13:11] == 3'h1 ? cfg_r[9:6] : cfg_r[4:1]))
        else $error("wrong request line watched");
    a_halt_blocks: assert property (s_halted |-> !xfer_ack_o)
        else $error("beat while halted");
    a_irq_drop: assert property ($fell(irq_o) |-> $past(wph_r))
        else $error("interrupt fell without a write");
endmodule
bind dma_chan_cfg dma_chan_cfg_chk dma_chan_cfg_chk_i (.sys_clk_i, .srst_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .busy_o,
    .xfer_ack_o, .req_line_o, .irq_o);
`default_nettype wire

// ### tb/dma_req_model.sv
// peripheral model driving the dma request lines
`timescale 1ns/10ps
`default_nettype none
module dma_req_model (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    // control
    input  wire logic       en_i,
    input  wire logic [3:0] line_i,
    input  wire logic       xfer_ack_i,
    // request lines
    output logic     [15:0] dma_req_o
);
    // a served peripheral withdraws for a cycle, then asks again while en_i is high
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !en_i) begin
            dma_req_o <= 16'h0;
        end else begin
            dma_req_o <= 16'(!xfer_ack_i) << line_i;
        end
    end
endmodule
`default_nettype wire
